// >>> hdl/mss_top.sv
// Behaviour
// - Main and auxiliary speeds are either summed or one is selected.
// - Switch input active selects auxiliary speed, else main speed.
// - Sequencer has three modes: single run, cyclic run, I/O select.
// - Single run: segments one upward, stop after the last configured.
// - Cyclic run: after the last segment restart from segment one.
// - I/O mode: decode select inputs into a segment and run its speed.
// - I/O mode: on a select input change, switch to the new segment.
// - Mode accepts 0 to 2 only; resets to single run.
// - Mode matters only for multi-speed; writable only while stopped.
// - Segment total accepts 1 to 16, resets to 16, writable anytime.
// - Every segment has its own speed and running time.
`timescale 1ns/1ps
`default_nettype none
`include "mss_defs.svh"

module mss_top
#(
  parameter int TICK_CYCLES = `MSS_TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               nrst,
  // Wishbone slave.
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Digital inputs from the external controller.
  input  wire logic               motor_enable_i,
  input  wire logic               speed_source_switch_input,
  input  wire logic [3:0]         seg_select_i,
  // Speed loop side.
  output logic signed [15:0]      speed_cmd_o,
  output logic                    motor_run_o,
  output logic      [3:0]         segment_o,
  output mss_pkg::mss_state_t     seq_state_o
);

  import mss_pkg::*;

  // Merges the low two byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] wb_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  sel);
    logic [15:0] v;
    v = old;
    if (sel[0])
      v[7:0] = wd[7:0];
    if (sel[1])
      v[15:8] = wd[15:8];
    return v;
  endfunction

  // Adds two speeds and clamps to the legal speed range.
  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic [15:0] b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    if (s > `MSS_SPEED_MAX)
      s = `MSS_SPEED_MAX;
    else if (s < `MSS_SPEED_MIN)
      s = `MSS_SPEED_MIN;
    return s[15:0];
  endfunction

  logic [5:0]  pins_s;
  logic        en_s;
  logic        sw_s;
  logic [3:0]  sel_s;

  mss_sync u_sync
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_i  ({motor_enable_i, speed_source_switch_input, seg_select_i}),
    .sync_o   (pins_s)
  );

  assign en_s  = pins_s[5];
  assign sw_s  = pins_s[4];
  assign sel_s = pins_s[3:0];

  // Registers.
  logic                ack_q;
  logic [31:0]         dat_q;
  mss_src_t            src_q;
  logic [15:0]         main_q;
  logic [15:0]         aux_q;
  logic [15:0]         comm_q;
  mss_mode_t           mode_q;
  logic [4:0]          total_q;
  mss_state_t          state_q;
  mss_state_t          state_d;
  logic [3:0]          seg_q;
  logic [3:0]          seg_d;
  logic                restart;
  logic [17:0]         pre_q;
  logic [15:0]         ms_q;
  logic [15:0]         speed_q;
  logic [15:0]         speed_d;
  logic                run_q;

  // Bus decode.
  logic [7:0]  bus_addr;
  logic        bus_req;
  logic        bus_wr;
  logic        hit_src;
  logic        hit_main;
  logic        hit_aux;
  logic        hit_comm;
  logic        hit_mode;
  logic        hit_total;
  logic        hit_status;
  logic        hit_speed;
  logic        hit_seg_spd;
  logic        hit_seg_tim;
  logic [3:0]  bus_idx;

  assign bus_addr    = {wb_adr_i[7:2], 2'h0};
  assign bus_req     = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr      = bus_req & wb_we_i;
  assign hit_src     = bus_addr == `MSS_OFS_SRC;
  assign hit_main    = bus_addr == `MSS_OFS_MAIN;
  assign hit_aux     = bus_addr == `MSS_OFS_AUX;
  assign hit_comm    = bus_addr == `MSS_OFS_COMM;
  assign hit_mode    = bus_addr == `MSS_OFS_MODE;
  assign hit_total   = bus_addr == `MSS_OFS_TOTAL;
  assign hit_status  = bus_addr == `MSS_OFS_STATUS;
  assign hit_speed   = bus_addr == `MSS_OFS_SPEED;
  assign hit_seg_spd = bus_addr[7:6] == `MSS_REGION_SEG_SPD;
  assign hit_seg_tim = bus_addr[7:6] == `MSS_REGION_SEG_TIM;
  assign bus_idx     = bus_addr[5:2];

  // Segment tables.
  logic [15:0] bus_spd;
  logic [15:0] bus_tim;
  logic [15:0] seq_spd;
  logic [15:0] seq_tim;
  logic [15:0] wr_seg_v;

  assign wr_seg_v = wb_merge(hit_seg_spd ? bus_spd : bus_tim,
                             wb_dat_i, wb_sel_i);

  mss_seg_mem u_mem
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .spd_we   (bus_wr & hit_seg_spd),
    .tim_we   (bus_wr & hit_seg_tim),
    .wr_idx   (bus_idx),
    .wr_data  (wr_seg_v),
    .bus_idx  (bus_idx),
    .bus_spd  (bus_spd),
    .bus_tim  (bus_tim),
    .seq_idx  (seg_q),
    .seq_spd  (seq_spd),
    .seq_tim  (seq_tim)
  );

  // Write values and their acceptance.
  logic [15:0] wr_src_v;
  logic [15:0] wr_main_v;
  logic [15:0] wr_aux_v;
  logic [15:0] wr_comm_v;
  logic [15:0] wr_mode_v;
  logic [15:0] wr_total_v;
  logic        stopped;
  logic        mode_ok;
  logic        total_ok;

  assign wr_src_v   = wb_merge({13'h0, src_q}, wb_dat_i, wb_sel_i);
  assign wr_main_v  = wb_merge(main_q, wb_dat_i, wb_sel_i);
  assign wr_aux_v   = wb_merge(aux_q, wb_dat_i, wb_sel_i);
  assign wr_comm_v  = wb_merge(comm_q, wb_dat_i, wb_sel_i);
  assign wr_mode_v  = wb_merge({14'h0, mode_q}, wb_dat_i, wb_sel_i);
  assign wr_total_v = wb_merge({11'h0, total_q}, wb_dat_i, wb_sel_i);
  assign stopped    = state_q != MSS_RUN;
  assign mode_ok    = bus_wr & hit_mode & stopped &
                      (wr_mode_v <= `MSS_MODE_MAX);
  assign total_ok   = bus_wr & hit_total &
                      (wr_total_v >= `MSS_TOTAL_MIN) &
                      (wr_total_v <= `MSS_TOTAL_MAX);

  // Read selection.
  logic [15:0] rd_word;

  assign rd_word = hit_src     ? {13'h0, src_q} :
                   hit_main    ? main_q :
                   hit_aux     ? aux_q :
                   hit_comm    ? comm_q :
                   hit_mode    ? {14'h0, mode_q} :
                   hit_total   ? {11'h0, total_q} :
                   hit_status  ? {9'h0, run_q, state_q, seg_q} :
                   hit_speed   ? speed_q :
                   hit_seg_spd ? bus_spd :
                   hit_seg_tim ? bus_tim : 16'h0000;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_req;
      dat_q <= (bus_req & ~wb_we_i) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      src_q   <= mss_src_t'(`MSS_RST_SRC);
      main_q  <= `MSS_RST_MAIN;
      aux_q   <= `MSS_RST_AUX;
      comm_q  <= `MSS_RST_COMM;
      mode_q  <= mss_mode_t'(`MSS_RST_MODE);
      total_q <= `MSS_RST_TOTAL;
    end
    else
    begin
      if (bus_wr & hit_src)
        src_q <= mss_src_t'(wr_src_v[2:0]);
      if (bus_wr & hit_main)
        main_q <= wr_main_v;
      if (bus_wr & hit_aux)
        aux_q <= wr_aux_v;
      if (bus_wr & hit_comm)
        comm_q <= wr_comm_v;
      if (mode_ok)
        mode_q <= mss_mode_t'(wr_mode_v[1:0]);
      if (total_ok)
        total_q <= wr_total_v[4:0];
    end
  end

  // Sequencer.
  logic        seq_go;
  logic        tick;
  logic        last_seg;
  logic        seg_done;

  assign seq_go   = en_s & (src_q == MSS_SRC_MULTI);
  assign tick     = pre_q == 18'(TICK_CYCLES - 1);
  assign last_seg = {1'b0, seg_q} >= (total_q - 5'h01);
  assign seg_done = (state_q == MSS_RUN) & (mode_q != MSS_IO) &
                    (ms_q >= seq_tim);

  always_comb
  begin
    state_d = state_q;
    seg_d   = seg_q;
    restart = 1'b0;
    case (state_q)
      MSS_IDLE:
      begin
        if (seq_go)
        begin
          state_d = MSS_RUN;
          seg_d   = (mode_q == MSS_IO) ? sel_s : 4'h0;
          restart = 1'b1;
        end
      end
      MSS_RUN:
      begin
        if (!seq_go)
          state_d = MSS_IDLE;
        else if (mode_q == MSS_IO)
        begin
          if (sel_s != seg_q)
          begin
            seg_d   = sel_s;
            restart = 1'b1;
          end
        end
        else if (seg_done)
        begin
          restart = 1'b1;
          if (!last_seg)
            seg_d = seg_q + 4'h1;
          else if (mode_q == MSS_CYCLIC)
            seg_d = 4'h0;
          else
            state_d = MSS_DONE;
        end
      end
      MSS_DONE:
      begin
        if (!seq_go)
          state_d = MSS_IDLE;
      end
      default:
        state_d = MSS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_q <= MSS_IDLE;
      seg_q   <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      seg_q   <= seg_d;
    end
  end

  // Running-time counters restart with every segment.
  always_ff @(posedge core_clk)
  begin
    if (!nrst || restart || state_q != MSS_RUN)
    begin
      pre_q <= 18'h00000;
      ms_q  <= 16'h0000;
    end
    else
    begin
      pre_q <= tick ? 18'h00000 : pre_q + 18'h00001;
      if (tick && ms_q != 16'hffff)
        ms_q <= ms_q + 16'h0001;
    end
  end

  // Speed reference selection.
  always_comb
  begin
    case (src_q)
      MSS_SRC_MAIN:   speed_d = main_q;
      MSS_SRC_AUX:    speed_d = aux_q;
      MSS_SRC_SWITCH: speed_d = sw_s ? aux_q : main_q;
      MSS_SRC_SUM:    speed_d = sat_add(main_q, aux_q);
      MSS_SRC_COMM:   speed_d = comm_q;
      MSS_SRC_MULTI:  speed_d = (state_q == MSS_RUN) ? seq_spd : 16'h0000;
      default:        speed_d = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      speed_q <= 16'h0000;
      run_q   <= 1'b0;
    end
    else
    begin
      speed_q <= speed_d;
      run_q   <= en_s & ~((src_q == MSS_SRC_MULTI) & (state_q != MSS_RUN));
    end
  end

  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = dat_q;
  assign speed_cmd_o = speed_q;
  assign motor_run_o = run_q;
  assign segment_o   = seg_q;
  assign seq_state_o = state_q;

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sum_ref_a: assert property ((src_q == MSS_SRC_SUM) |=>
    speed_q == $past(sat_add(main_q, aux_q)))
    else $error("sum reference wrong");
  switch_aux_a: assert property ((src_q == MSS_SRC_SWITCH) && sw_s
    |=> speed_q == $past(aux_q))
    else $error("switch did not select auxiliary speed");
  mode_range_a: assert property (mode_q inside {MSS_SINGLE, MSS_CYCLIC,
    MSS_IO})
    else $error("mode out of range");
  mode_lock_a: assert property ((state_q == MSS_RUN) |=>
    mode_q == $past(mode_q))
    else $error("mode changed while running");
  total_range_a: assert property (total_q >= 5'h01 && total_q <= 5'h10)
    else $error("segment total out of range");
  single_stop_a: assert property (seg_done && last_seg && seq_go &&
    mode_q == MSS_SINGLE |=> state_q == MSS_DONE ##1 speed_q == 16'h0000)
    else $error("single run did not stop");
  seg_step_a: assert property (seg_done && !last_seg && seq_go
    |=> seg_q == $past(seg_q) + 4'h1 && ms_q == 16'h0000)
    else $error("segment did not advance");
  cyc_wrap_a: assert property (seg_done && last_seg && seq_go &&
    mode_q == MSS_CYCLIC |=> seg_q == 4'h0 && state_q == MSS_RUN)
    else $error("cyclic run did not wrap");
  io_follow_a: assert property (state_q == MSS_RUN && mode_q == MSS_IO &&
    seq_go ##1 sel_s != seg_q && seq_go |=> seg_q == $past(sel_s) ##1
    speed_q == $past(seq_spd))
    else $error("select change not followed");
  time_hold_a: assert property (state_q == MSS_RUN && mode_q != MSS_IO &&
    ms_q < seq_tim && seq_go |=> seg_q == $past(seg_q))
    else $error("segment left before its time");
  disable_idle_a: assert property (!en_s |=> state_q == MSS_IDLE)
    else $error("sequencer not idle after disable");
  ack_pulse_a: assert property (ack_q |=> !ack_q)
    else $error("ack held more than one cycle");

  single_done_c: cover property (state_q == MSS_RUN ##1 state_q == MSS_DONE);
  cyc_wrap_c: cover property (mode_q == MSS_CYCLIC && seg_q != 4'h0
    ##1 seg_q == 4'h0 && state_q == MSS_RUN);
  io_switch_c: cover property (mode_q == MSS_IO && state_q == MSS_RUN
    ##1 $changed(seg_q));
  aux_sel_c: cover property (src_q == MSS_SRC_SWITCH && sw_s);

endmodule
`default_nettype wire

// >>> include/mss_defs.svh
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

// Register byte offsets on the bus.
`define MSS_OFS_SRC        8'h00
`define MSS_OFS_MAIN       8'h04
`define MSS_OFS_AUX        8'h08
`define MSS_OFS_COMM       8'h0c
`define MSS_OFS_MODE       8'h10
`define MSS_OFS_TOTAL      8'h14
`define MSS_OFS_STATUS     8'h18
`define MSS_OFS_SPEED      8'h1c

// Segment tables: address bits 7:6 select the table, 5:2 the segment.
`define MSS_REGION_SEG_SPD 2'h1
`define MSS_REGION_SEG_TIM 2'h2

// Reset values.
`define MSS_RST_SRC        3'h0
`define MSS_RST_MAIN       16'h01f4
`define MSS_RST_AUX        16'h01f4
`define MSS_RST_COMM       16'h0000
`define MSS_RST_MODE       2'h0
`define MSS_RST_TOTAL      5'h10
`define MSS_RST_SEG_SPD    16'h0000
`define MSS_RST_SEG_TIM    16'h000a

// Accepted ranges.
`define MSS_MODE_MAX       16'h0002
`define MSS_TOTAL_MIN      16'h0001
`define MSS_TOTAL_MAX      16'h0010
`define MSS_SPEED_MAX      17'sh07fff
`define MSS_SPEED_MIN      (-17'sh07fff)

// Running-time tick: one unit of segment time.
`define MSS_TICK_MS        1
`define MSS_CLK_MHZ        250
`define MSS_TICK_CYCLES    (`MSS_TICK_MS * `MSS_CLK_MHZ * 1000)

`endif

// >>> include/mss_pkg.sv
package mss_pkg;

  typedef enum logic [2:0]
  {
    MSS_SRC_MAIN,
    MSS_SRC_AUX,
    MSS_SRC_SWITCH,
    MSS_SRC_SUM,
    MSS_SRC_COMM,
    MSS_SRC_MULTI,
    MSS_SRC_UPDOWN,
    MSS_SRC_SINE
  } mss_src_t;

  typedef enum logic [1:0]
  {
    MSS_SINGLE,
    MSS_CYCLIC,
    MSS_IO
  } mss_mode_t;

  typedef enum logic [1:0]
  {
    MSS_IDLE,
    MSS_RUN,
    MSS_DONE
  } mss_state_t;

endpackage

// >>> hdl/mss_sync.sv
`timescale 1ns/1ps
`default_nettype none

module mss_sync
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Pin levels in and synchronised levels out.
  input  wire logic [5:0] async_i,
  output logic      [5:0] sync_o
);

  logic [5:0] meta_q;
  logic [5:0] sync_q;

  // Two flops; the first is read only by the second.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule
`default_nettype wire

// >>> hdl/mss_seg_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "mss_defs.svh"

module mss_seg_mem
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Write port.
  input  wire logic        spd_we,
  input  wire logic        tim_we,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  // Bus read port.
  input  wire logic [3:0]  bus_idx,
  output logic      [15:0] bus_spd,
  output logic      [15:0] bus_tim,
  // Sequencer read port.
  input  wire logic [3:0]  seq_idx,
  output logic      [15:0] seq_spd,
  output logic      [15:0] seq_tim
);

  logic [15:0] spd_mem [16];
  logic [15:0] tim_mem [16];

  // Each segment keeps its own speed and running time.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 16; i++)
      begin
        spd_mem[i] <= `MSS_RST_SEG_SPD;
        tim_mem[i] <= `MSS_RST_SEG_TIM;
      end
    end
    else
    begin
      if (spd_we)
        spd_mem[wr_idx] <= wr_data;
      if (tim_we)
        tim_mem[wr_idx] <= wr_data;
    end
  end

  assign bus_spd = spd_mem[bus_idx];
  assign bus_tim = tim_mem[bus_idx];
  assign seq_spd = spd_mem[seq_idx];
  assign seq_tim = tim_mem[seq_idx];

endmodule
`default_nettype wire

// >>> sim/mss_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module mss_ctrl_model
(
  // Clock.
  input  wire logic       core_clk,
  // Levels requested by the test sequence.
  input  wire logic       req_en,
  input  wire logic       req_sw,
  input  wire logic [3:0] req_sel,
  // Controller outputs towards the drive.
  output logic            en_pin,
  output logic            sw_pin,
  output logic      [3:0] sel_pin
);
  // Pins move just after a clock edge, as a controller output would.
  always @(posedge core_clk)
  begin
    en_pin  <= req_en;
    sw_pin  <= req_sw;
    sel_pin <= req_sel;
  end
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mss_defs.svh"

module tb_top;
  import mss_pkg::*;

  localparam int TICK = 4;
  localparam logic [15:0] SRC_EXP [8] =
    '{16'h64, 16'hc8, 16'hc8, 16'h12c, 16'h55, 16'h0, 16'h0, 16'h0};

  logic               core_clk;
  logic               nrst;
  logic               cyc;
  logic               stb;
  logic               we;
  logic        [7:0]  adr;
  logic        [3:0]  sel;
  logic        [31:0] dat_w;
  logic        [31:0] dat_r;
  logic               ack;
  logic               req_en;
  logic               req_sw;
  logic        [3:0]  req_sel;
  logic               en_pin;
  logic               sw_pin;
  logic        [3:0]  sel_pin;
  logic signed [15:0] speed;
  logic               run;
  logic        [3:0]  seg;
  mss_state_t         state;
  int                 errors;
  int                 checks_done;
  int                 n;

  mss_top #(.TICK_CYCLES(TICK)) u_mss_top
  (
    .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .motor_enable_i(en_pin),
    .speed_source_switch_input(sw_pin), .seg_select_i(sel_pin),
    .speed_cmd_o(speed), .motor_run_o(run), .segment_o(seg),
    .seq_state_o(state)
  );

  mss_ctrl_model u_mss_ctrl_model
  (
    .core_clk(core_clk), .req_en(req_en), .req_sw(req_sw),
    .req_sel(req_sel), .en_pin(en_pin), .sw_pin(sw_pin), .sel_pin(sel_pin)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge core_clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= 4'hf;
    dat_w <= d;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    chk({31'h0, ack}, 32'h1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(a, 1'b1, {16'h0, d}, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk(q, {16'h0, exp});
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d,
                       input logic [15:0] exp);
    wr(a, d);
    rd(a, exp);
  endtask

  task automatic seg_set(input logic [3:0] i, input logic [15:0] spd,
                         input logic [15:0] tim);
    wr({`MSS_REGION_SEG_SPD, i, 2'h0}, spd);
    wr({`MSS_REGION_SEG_TIM, i, 2'h0}, tim);
  endtask

  task automatic pins(input logic e, input logic s, input logic [3:0] g);
    @(posedge core_clk);
    req_en  <= e;
    req_sw  <= s;
    req_sel <= g;
  endtask

  task automatic wait_for(input mss_state_t s, input logic [3:0] g);
    n = 0;
    while (!(state === s && seg === g) && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    chk({26'h0, state, seg}, {26'h0, s, g});
  endtask

  task automatic chk_speed(input logic [15:0] exp);
    chk({16'h0, speed}, {16'h0, exp});
  endtask

  task automatic test_end(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    errors++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end

  initial
  begin
    nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
    sel = 4'hf; dat_w = 32'h0; req_en = 1'b0; req_sw = 1'b0;
    req_sel = 4'h0; errors = 0; checks_done = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    // Reset values and an unmapped address.
    rd(`MSS_OFS_AUX, 16'h01f4);
    rd(`MSS_OFS_COMM, 16'h0000);
    rd(`MSS_OFS_MODE, 16'h0000);
    rd(`MSS_OFS_TOTAL, 16'h0010);
    rd(8'h40, 16'h0000);
    rd(8'h80, 16'h000a);
    wr_rd(8'h20, 16'h1234, 16'h0000);
    test_end("reset");
    // Every speed source, the switch input and the saturated sum.
    wr(`MSS_OFS_MAIN, 16'h0064);
    wr(`MSS_OFS_AUX, 16'h00c8);
    wr(`MSS_OFS_COMM, 16'h0055);
    wr(`MSS_OFS_SRC, 16'h0002);
    repeat (3) @(posedge core_clk);
    chk_speed(16'h0064);
    pins(1'b0, 1'b1, 4'h0);
    repeat (6) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      wr(`MSS_OFS_SRC, 16'(i));
      repeat (3) @(posedge core_clk);
      chk_speed(SRC_EXP[i]);
      rd(`MSS_OFS_SPEED, SRC_EXP[i]);
    end
    wr(`MSS_OFS_MAIN, 16'h7fff);
    wr(`MSS_OFS_SRC, 16'h0003);
    repeat (3) @(posedge core_clk);
    chk_speed(16'h7fff);
    test_end("source");
    // Range limits of mode and total.
    wr_rd(`MSS_OFS_MODE, 16'h0003, 16'h0000);
    wr_rd(`MSS_OFS_MODE, 16'h0002, 16'h0002);
    wr_rd(`MSS_OFS_MODE, 16'h0001, 16'h0001);
    wr_rd(`MSS_OFS_MODE, 16'h0000, 16'h0000);
    wr_rd(`MSS_OFS_TOTAL, 16'h0000, 16'h0010);
    wr_rd(`MSS_OFS_TOTAL, 16'h0011, 16'h0010);
    wr_rd(`MSS_OFS_TOTAL, 16'h0001, 16'h0001);
    test_end("limits");
    // Single run over two segments.
    seg_set(4'h0, 16'h000b, 16'h0002);
    seg_set(4'h1, 16'h0016, 16'h0003);
    seg_set(4'h2, 16'h0021, 16'h0002);
    wr(`MSS_OFS_TOTAL, 16'h0002);
    wr(`MSS_OFS_SRC, 16'h0005);
    pins(1'b1, 1'b0, 4'h0);
    wait_for(MSS_RUN, 4'h0);
    @(posedge core_clk);
    chk_speed(16'h000b);
    chk({31'h0, run}, 32'h1);
    wait_for(MSS_RUN, 4'h1);
    chk({31'h0, n >= 7 && n <= 10}, 32'h1);
    @(posedge core_clk);
    chk_speed(16'h0016);
    wait_for(MSS_DONE, 4'h1);
    chk({31'h0, n >= 10 && n <= 14}, 32'h1);
    @(posedge core_clk);
    chk({31'h0, run}, 32'h0);
    rd(`MSS_OFS_STATUS, 16'h0021);
    test_end("single");
    // Cyclic run, mode lock while running, return to idle.
    pins(1'b0, 1'b0, 4'h0);
    repeat (6) @(posedge core_clk);
    chk({30'h0, state}, {30'h0, MSS_IDLE});
    wr_rd(`MSS_OFS_MODE, 16'h0001, 16'h0001);
    pins(1'b1, 1'b0, 4'h0);
    wait_for(MSS_RUN, 4'h0);
    wait_for(MSS_RUN, 4'h1);
    wait_for(MSS_RUN, 4'h0);
    wr_rd(`MSS_OFS_MODE, 16'h0000, 16'h0001);
    test_end("cyclic");
    // Segment chosen by the select inputs.
    pins(1'b0, 1'b0, 4'h3);
    repeat (6) @(posedge core_clk);
    wr_rd(`MSS_OFS_MODE, 16'h0002, 16'h0002);
    seg_set(4'h3, 16'h002c, 16'h0002);
    seg_set(4'h5, 16'hfffb, 16'h0002);
    pins(1'b1, 1'b0, 4'h3);
    wait_for(MSS_RUN, 4'h3);
    repeat (2) @(posedge core_clk);
    chk_speed(16'h002c);
    pins(1'b1, 1'b0, 4'h5);
    wait_for(MSS_RUN, 4'h5);
    repeat (2) @(posedge core_clk);
    chk_speed(16'hfffb);
    test_end("io_select");
    report_and_stop();
  end
endmodule

`default_nettype wire
